// ### dcl_clk_gen.v
// quadrature clock pair generator scaled by the output divider
`timescale 1ns/10ps
`default_nettype none

module dcl_clk_gen #(
	parameter CW = 5
) (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       ce,
	input  wire       hold,
	input  wire [1:0] div_sel,
	output reg  [1:0] clk_true,
	output reg  [1:0] clk_comp
);

	// a period is four quarters of n cycles, n = 1, 2, 4 or 8
	function [CW-1:0] quarter;
		input [1:0] sel;
		begin
			quarter = {{(CW-1){1'b0}}, 1'b1} << sel;
		end
	endfunction

	reg  [CW-1:0] cnt_q;
	reg  [1:0]    sel_q;
	wire [CW-1:0] n       = quarter(div_sel);
	wire [CW-1:0] last    = (n << 2) - {{(CW-1){1'b0}}, 1'b1};
	// parked at all ones so a fresh period starts with the second pair low
	wire          restart = hold || (div_sel != sel_q);
	wire [CW-1:0] cnt_d   = restart ? {CW{1'b1}}
	                        : (cnt_q >= last) ? {CW{1'b0}}
	                        : cnt_q + {{(CW-1){1'b0}}, 1'b1};
	// second output trails by one quarter
	wire [CW-1:0] lag_pos = (cnt_d >= n) ? cnt_d - n : cnt_d + last + 1'b1 - n;
	wire          ph0     = cnt_d < (n << 1);
	wire          ph1     = lag_pos < (n << 1);

	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q    <= {CW{1'b1}};
			sel_q    <= 2'h0;
			clk_true <= 2'h0;
			clk_comp <= 2'h3;
		end else if (ce) begin
			cnt_q <= cnt_d;
			sel_q <= div_sel;
			if (hold) begin
				clk_true <= 2'h0; // see [RULE_01]
				clk_comp <= 2'h3;
			end else begin
				clk_true <= {ph1, ph0};
				clk_comp <= {~ph1, ~ph0};
			end
		end
	end

endmodule

`default_nettype wire

// ### dcl_defines.vh
// constants shared by the divider configuration loader files
`ifndef DCL_DEFINES_VH
`define DCL_DEFINES_VH

// ----------------------------------------------------------------
// field widths and shift register layout
// ----------------------------------------------------------------
`define DCL_MULT_W        9
`define DCL_DIV_W         2
`define DCL_SR_W          11
`define DCL_SR_DIV_HI     10
`define DCL_SR_DIV_LO     9
`define DCL_SR_MULT_HI    8

// ----------------------------------------------------------------
// reset values of the held settings
// ----------------------------------------------------------------
`define DCL_RST_MULT      9'h00A
`define DCL_RST_DIV       2'h0

// ----------------------------------------------------------------
// output divider codes
// ----------------------------------------------------------------
`define DCL_DIV_BY1       2'h0
`define DCL_DIV_BY2       2'h1
`define DCL_DIV_BY4       2'h2
`define DCL_DIV_BY8       2'h3

// ----------------------------------------------------------------
// programming window for a 25 MHz reference
// ----------------------------------------------------------------
`define DCL_MULT_MIN_25M  9'h00A
`define DCL_MULT_MAX_25M  9'h01C

// ----------------------------------------------------------------
// register offsets (byte addresses) and fields
// ----------------------------------------------------------------
`define DCL_AW            8
`define DCL_OFS_CTRL      8'h00
`define DCL_OFS_STATUS    8'h04
`define DCL_OFS_SETTING   8'h08
`define DCL_OFS_SHIFT     8'h0C
`define DCL_OFS_LOADS     8'h10
`define DCL_CTRL_HOLD     0
`define DCL_SET_DIV_LSB   16
`define DCL_RESP_OKAY     2'h0
`define DCL_RESP_SLVERR   2'h2

`endif

// ### dcl_host_model.sv
// host controller model driving the configuration pins
`timescale 1ns/10ps
`default_nettype none
module dcl_host_model #(
	parameter REF_10M = 0
) (
	input  wire logic  aclk,
	output logic       force_low,
	output logic       strobe_n,
	output logic [8:0] mult,
	output logic       div_hi,
	output logic       div_lo,
	output logic       sclk,
	output logic       sdata,
	output logic       slatch
);
	initial begin
		force_low = 1'b0;
		strobe_n = 1'b1;
		mult = 9'h00A;
		div_hi = 1'b0;
		div_lo = 1'b0;
		sclk = 1'b0;
		sdata = 1'b0;
		slatch = 1'b0;
	end
	// pins pass a two-flop synchroniser, so every level but the released data line stands four cycles
	task automatic settle;
		repeat (4) @(posedge aclk);
	endtask
	function automatic logic [8:0] pick_m(input logic [15:0] r);
		int lo;
		int hi;
		lo = REF_10M ? 25 : 10;
		hi = REF_10M ? 70 : 28;
		return 9'(lo + int'(r) % (hi - lo + 1));
	endfunction
	task automatic set_ctl(input logic f, input logic s);
		@(posedge aclk);
		force_low <= f;
		strobe_n <= s;
		settle();
	endtask
	task automatic put_par(input logic [8:0] m, input logic [1:0] d);
		@(posedge aclk);
		mult <= m;
		{div_hi, div_lo} <= d;
		settle();
	endtask
	// released data line shows the inverse, never the last bit
	task automatic shift_bit(input logic b);
		@(posedge aclk);
		sdata <= b;
		settle();
		sclk <= 1'b1;
		settle();
		sclk <= 1'b0;
		settle();
		sdata <= ~b;
	endtask
	task automatic shift_word(input logic [10:0] w);
		for (int i = 10; i >= 0; i--) shift_bit(w[i]);
	endtask
	// latch moves only while the shift clock is low
	task automatic set_latch(input logic v);
		@(posedge aclk);
		slatch <= v;
		settle();
	endtask
endmodule
`default_nettype wire

// ### dcl_sync.v
// two-flop synchroniser bank for the configuration pins
`timescale 1ns/10ps
`default_nettype none

module dcl_sync #(
	parameter W = 15
) (
	input  wire         aclk,
	input  wire         aresetn,
	input  wire         ce,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);

	// first stage is read only by the second stage
	reg [W-1:0] meta_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_q   <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else if (ce) begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

`default_nettype wire

// ### dcl_top.v
// divider configuration loader: parallel and serial pins, AXI4-Lite status
//
// Notes on behaviour
// [RULE_01] force-low high holds clock pairs low, loaded settings untouched.
// [RULE_02] strobe low: parallel pins pass straight through; diagnostic output low.
// [RULE_03] strobe rising with serial latch low captures parallel values.
// [RULE_04] strobe high, latch low: shift serial data on each shift clock rise.
// [RULE_05] latch rising with shift clock low transfers shift register to settings.
// [RULE_06] latch falling with shift clock low freezes transferred settings.
// [RULE_07] strobe high, latch low, no clock edge: nothing changes.
// [RULE_08] latch held high: each shifted bit reaches the multiplier at once.
// [RULE_09] multiplier is unsigned binary, weights 256 down to 1.
// [RULE_10] controller keeps multiplier 10..28 with a 25 MHz reference.
// [RULE_11] divider code 00,01,10,11 means divide by 1,2,4,8.
// [RULE_12] controller keeps multiplier 25..70 with a 10 MHz reference.
// [RULE_13] shift register is eleven bits, divider high bit sent first.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dcl_defines.vh"

module dcl_top #(
	parameter MULT_W = `DCL_MULT_W,
	parameter DIV_W  = `DCL_DIV_W,
	parameter SR_W   = `DCL_SR_W,
	parameter CNT_W  = 16
) (
	input  wire              aclk,
	input  wire              aresetn,
	input  wire              ce,
	// ------------------------------------------------------------
	// configuration pins
	// ------------------------------------------------------------
	input  wire              output_force_low,
	input  wire              parallel_latch_strobe_n,
	input  wire [MULT_W-1:0] multiplier_pins,
	input  wire              post_divider_select_hi,
	input  wire              post_divider_select_lo,
	input  wire              serial_shift_clk,
	input  wire              serial_data,
	input  wire              serial_latch,
	output wire [1:0]        clk_out_true,
	output wire [1:0]        clk_out_comp,
	output reg               diag_out,
	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	input  wire [`DCL_AW-1:0] s_axi_awaddr,
	input  wire [2:0]        s_axi_awprot,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [`DCL_AW-1:0] s_axi_araddr,
	input  wire [2:0]        s_axi_arprot,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready
);

	// five serial and control pins, then the divider and multiplier pins
	localparam SYNC_W = MULT_W + DIV_W + 5;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------

	// unsigned weight of the multiplier bits, msb 256 down to lsb 1
	function [31:0] mult_value;
		input [MULT_W-1:0] m;
		integer i;
		begin
			mult_value = 32'h0;
			for (i = 0; i < MULT_W; i = i + 1) begin
				if (m[i])
					mult_value = mult_value + (32'h1 << i); // see [RULE_09]
			end
		end
	endfunction

	// division ratio for a divider code
	function [3:0] div_ratio;
		input [DIV_W-1:0] code;
		begin
			case (code)
				`DCL_DIV_BY1: div_ratio = 4'h1; // see [RULE_11]
				`DCL_DIV_BY2: div_ratio = 4'h2;
				`DCL_DIV_BY4: div_ratio = 4'h4;
				default:      div_ratio = 4'h8;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers and edge detection
	// ------------------------------------------------------------
	wire [SYNC_W-1:0] pins_s;

	dcl_sync #(
		.W (SYNC_W)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.async_in ({output_force_low, parallel_latch_strobe_n, serial_latch,
		            serial_shift_clk, serial_data, post_divider_select_hi,
		            post_divider_select_lo, multiplier_pins}),
		.sync_out (pins_s)
	);

	wire              force_s  = pins_s[SYNC_W-1];
	wire              strobe_s = pins_s[SYNC_W-2];
	wire              latch_s  = pins_s[SYNC_W-3];
	wire              sclk_s   = pins_s[SYNC_W-4];
	wire              sdata_s  = pins_s[SYNC_W-5];
	wire [DIV_W-1:0]  div_s    = pins_s[MULT_W+DIV_W-1:MULT_W];
	wire [MULT_W-1:0] mult_s   = pins_s[MULT_W-1:0];

	// previous values; reset to the pin reset level to avoid a false edge
	reg strobe_prev_q;
	reg latch_prev_q;
	reg sclk_prev_q;

	wire strobe_rise = strobe_s & ~strobe_prev_q;
	wire latch_rise  = latch_s & ~latch_prev_q;
	wire latch_fall  = ~latch_s & latch_prev_q;
	wire sclk_rise   = sclk_s & ~sclk_prev_q;

	// ------------------------------------------------------------
	// held settings and shift register
	// ------------------------------------------------------------
	reg [MULT_W-1:0] mult_q;
	reg [DIV_W-1:0]  div_q;
	reg [SR_W-1:0]   shift_q;
	reg              follow_q;
	reg              frozen_q;
	reg [CNT_W-1:0]  loads_q;
	reg              hold_sw_q;

	// first bit sent lands at the top: divider hi, divider lo, then msb..lsb
	wire [SR_W-1:0] shift_next = {shift_q[SR_W-2:0], sdata_s}; // see [RULE_13]

	always @(posedge aclk) begin
		if (!aresetn) begin
			strobe_prev_q <= 1'b0;
			latch_prev_q  <= 1'b0;
			sclk_prev_q   <= 1'b0;
			mult_q        <= `DCL_RST_MULT;
			div_q         <= `DCL_RST_DIV;
			shift_q       <= {SR_W{1'b0}};
			follow_q      <= 1'b0;
			frozen_q      <= 1'b0;
			loads_q       <= {CNT_W{1'b0}};
			diag_out      <= 1'b0;
		end else if (ce) begin
			strobe_prev_q <= strobe_s;
			latch_prev_q  <= latch_s;
			sclk_prev_q   <= sclk_s;
			// force-low is not looked at here: settings survive it, see [RULE_01]
			if (!strobe_s) begin
				mult_q   <= mult_s; // see [RULE_02]
				div_q    <= div_s;
				follow_q <= 1'b0;
				frozen_q <= 1'b0;
				diag_out <= 1'b0;   // see [RULE_02]
			end else begin
				diag_out <= shift_q[SR_W-1];
				if (strobe_rise && !latch_s) begin
					mult_q <= mult_s; // see [RULE_03]
					div_q  <= div_s;
				end
				if (sclk_rise) begin
					shift_q <= shift_next; // see [RULE_04]
					if (latch_s && !latch_rise)
						mult_q <= shift_next[`DCL_SR_MULT_HI:0]; // see [RULE_08]
				end
				if (latch_rise && !sclk_s) begin
					mult_q   <= shift_q[`DCL_SR_MULT_HI:0]; // see [RULE_05]
					div_q    <= shift_q[`DCL_SR_DIV_HI:`DCL_SR_DIV_LO];
					follow_q <= 1'b1;
					frozen_q <= 1'b0;
					loads_q  <= loads_q + {{(CNT_W-1){1'b0}}, 1'b1};
				end
				if (latch_fall && !sclk_s) begin
					// nothing more reaches the settings until the next event
					follow_q <= 1'b0; // see [RULE_06]
					frozen_q <= 1'b1;
				end
				// latch low with no shift clock edge leaves all as is, see [RULE_07]
			end
		end
	end

	// ------------------------------------------------------------
	// clock output pairs
	// ------------------------------------------------------------
	dcl_clk_gen #(
		.CW (5)
	) u_clk_gen (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.hold     (force_s | hold_sw_q), // see [RULE_01]
		.div_sel  (div_q),
		.clk_true (clk_out_true),
		.clk_comp (clk_out_comp)
	);

	// ------------------------------------------------------------
	// status words
	// ------------------------------------------------------------
	// range flag only advises software; the pins may still load anything
	wire in_range_25m = (mult_q >= `DCL_MULT_MIN_25M) &&
	                    (mult_q <= `DCL_MULT_MAX_25M); // see [RULE_10]

	wire [31:0] status_word = {24'h0, in_range_25m, frozen_q, follow_q,
	                           strobe_s, force_s, hold_sw_q, diag_out,
	                           force_s | hold_sw_q};
	wire [31:0] mult_num     = mult_value(mult_q);
	wire [31:0] setting_word = {8'h00, div_ratio(div_q), {(4-DIV_W){1'b0}},
	                            div_q, {(16-MULT_W){1'b0}}, mult_num[MULT_W-1:0]};

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	reg [`DCL_AW-1:0] waddr_q;
	reg [31:0]        wdata_q;
	reg [3:0]         wstrb_q;
	reg               aw_have_q;
	reg               w_have_q;

	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take  = s_axi_wvalid & s_axi_wready;
	wire aw_ok   = aw_have_q | aw_take;
	wire w_ok    = w_have_q | w_take;
	wire [`DCL_AW-1:0] wa = aw_have_q ? waddr_q : s_axi_awaddr;
	wire [31:0]        wd = w_have_q ? wdata_q : s_axi_wdata;
	wire [3:0]         ws = w_have_q ? wstrb_q : s_axi_wstrb;
	wire               do_write = aw_ok & w_ok & ~s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `DCL_RESP_OKAY;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			waddr_q       <= {`DCL_AW{1'b0}};
			wdata_q       <= 32'h0;
			wstrb_q       <= 4'h0;
			hold_sw_q     <= 1'b0;
		end else if (ce) begin
			if (aw_take) begin
				waddr_q       <= s_axi_awaddr;
				aw_have_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				w_have_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wa == `DCL_OFS_CTRL) begin
					if (ws[0])
						hold_sw_q <= wd[`DCL_CTRL_HOLD];
					s_axi_bresp <= `DCL_RESP_OKAY;
				end else if (wa == `DCL_OFS_STATUS || wa == `DCL_OFS_SETTING ||
				             wa == `DCL_OFS_SHIFT || wa == `DCL_OFS_LOADS) begin
					// read-only words ignore the data
					s_axi_bresp <= `DCL_RESP_OKAY;
				end else begin
					s_axi_bresp <= `DCL_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `DCL_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `DCL_RESP_OKAY;
				if (s_axi_araddr == `DCL_OFS_CTRL) begin
					s_axi_rdata <= {31'h0, hold_sw_q};
				end else if (s_axi_araddr == `DCL_OFS_STATUS) begin
					s_axi_rdata <= status_word;
				end else if (s_axi_araddr == `DCL_OFS_SETTING) begin
					s_axi_rdata <= setting_word;
				end else if (s_axi_araddr == `DCL_OFS_SHIFT) begin
					s_axi_rdata <= {{(32-SR_W){1'b0}}, shift_q};
				end else if (s_axi_araddr == `DCL_OFS_LOADS) begin
					s_axi_rdata <= {{(32-CNT_W){1'b0}}, loads_q};
				end else begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `DCL_RESP_SLVERR;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// ### dcl_top_sva.sv
// port checker for the divider configuration loader
`timescale 1ns/10ps
`default_nettype none
module dcl_top_sva (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        output_force_low,
	input wire logic        parallel_latch_strobe_n,
	input wire logic [1:0]  clk_out_true,
	input wire logic [1:0]  clk_out_comp,
	input wire logic        diag_out,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// four samples cover the synchroniser fill plus the output flop
	AST_FORCE: assert property (output_force_low [*4] |-> clk_out_true == 2'h0)
		else $error("clock pair not held low");
	AST_COMP: assert property (clk_out_comp == ~clk_out_true)
		else $error("complement output not inverse");
	AST_DIAG: assert property (!parallel_latch_strobe_n [*4] |-> !diag_out)
		else $error("diagnostic output high in parallel mode");
	AST_LAG: assert property ($rose(clk_out_true[0]) |-> !clk_out_true[1])
		else $error("second pair not lagging");
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_RANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	AST_BANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write answer late");
endmodule
bind dcl_top dcl_top_sva i_sva (
	.aclk(aclk), .aresetn(aresetn), .output_force_low(output_force_low),
	.parallel_latch_strobe_n(parallel_latch_strobe_n), .clk_out_true(clk_out_true),
	.clk_out_comp(clk_out_comp), .diag_out(diag_out), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);
`default_nettype wire

// ### tb_divider_config_loader.sv
// self-checking testbench for the divider configuration loader
`timescale 1ns/10ps
`default_nettype none
`include "dcl_defines.vh"
module tb_divider_config_loader;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        fl, sn, dh, dl, sck, sd, sl, diag;
	logic [8:0]  mp, m;
	logic [1:0]  ct, cc, bresp, rresp, r, dv;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [15:0] rnd = 16'h0021;
	logic [10:0] fr;
	logic        ce = 1'b1;
	logic [3:0]  wstrb = 4'hF;
	int          nr;
	int          failures = 0;
	int          n_compared = 0;
	initial forever #5 aclk = ~aclk;
	dcl_host_model i_host (.aclk(aclk), .force_low(fl), .strobe_n(sn), .mult(mp),
		.div_hi(dh), .div_lo(dl), .sclk(sck), .sdata(sd), .slatch(sl));
	dcl_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .output_force_low(fl),
		.parallel_latch_strobe_n(sn), .multiplier_pins(mp), .post_divider_select_hi(dh),
		.post_divider_select_lo(dl), .serial_shift_clk(sck), .serial_data(sd),
		.serial_latch(sl), .clk_out_true(ct), .clk_out_comp(cc), .diag_out(diag),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] exp_set(input logic [8:0] em, input logic [1:0] ed);
		return {8'h00, 4'h1 << ed, 2'h0, ed, 7'h00, em};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// rising edges of the first pair over 32 cycles
	task automatic count_rises(output int n);
		logic p;
		n = 0;
		@(posedge aclk);
		p = ct[0];
		repeat (32) begin
			@(posedge aclk);
			if (ct[0] && !p)
				n++;
			p = ct[0];
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		end_of_test();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		i_host.settle();
		rd(`DCL_OFS_SETTING);
		chk(v, exp_set(`DCL_RST_MULT, `DCL_RST_DIV));
		i_host.set_ctl(1'b0, 1'b0);
		// range ends first and last, random codes between
		for (int d = 0; d < 4; d++) begin
			rnd = lfsr(rnd);
			m = i_host.pick_m(d == 0 ? 16'h0 : d == 3 ? 16'd18 : rnd);
			i_host.put_par(m, 2'(d));
			rd(`DCL_OFS_SETTING);
			chk(v, exp_set(m, 2'(d)));
			rd(`DCL_OFS_STATUS);
			chk({31'h0, v[1]}, 32'h0);
		end
		i_host.set_ctl(1'b0, 1'b1);
		i_host.put_par(~m, 2'h1);
		rd(`DCL_OFS_SETTING);
		chk(v, exp_set(m, 2'h3));
		rnd = lfsr(rnd);
		fr = {rnd[1:0], i_host.pick_m(lfsr(rnd))};
		i_host.shift_word(fr);
		rd(`DCL_OFS_SHIFT);
		chk(v, {21'h0, fr});
		rd(`DCL_OFS_STATUS);
		chk({31'h0, v[1]}, {31'h0, fr[10]});
		rd(`DCL_OFS_SETTING);
		chk(v, exp_set(m, 2'h3));
		i_host.set_latch(1'b1);
		rd(`DCL_OFS_SETTING);
		chk(v, exp_set(fr[8:0], fr[10:9]));
		rd(`DCL_OFS_LOADS);
		chk(v & 32'h0000FFFF, 32'h1);
		dv = fr[10:9];
		i_host.shift_bit(rnd[5]);
		fr = {fr[9:0], rnd[5]};
		rd(`DCL_OFS_SETTING);
		chk(v, exp_set(fr[8:0], dv));
		i_host.set_latch(1'b0);
		rd(`DCL_OFS_STATUS);
		chk({30'h0, v[6:5]}, 32'h2);
		i_host.shift_bit(~rnd[5]);
		rd(`DCL_OFS_SETTING);
		chk(v, exp_set(fr[8:0], dv));
		i_host.set_ctl(1'b1, 1'b1);
		chk({28'h0, ct, cc}, 32'h3);
		rd(`DCL_OFS_SETTING);
		chk(v, exp_set(fr[8:0], dv));
		i_host.set_ctl(1'b0, 1'b1);
		wr(`DCL_OFS_CTRL, 32'h1);
		chk({30'h0, r}, {30'h0, `DCL_RESP_OKAY});
		i_host.settle();
		chk({28'h0, ct, cc}, 32'h3);
		rd(`DCL_OFS_STATUS);
		chk({31'h0, v[2]}, 32'h1);
		wr(`DCL_OFS_CTRL, 32'h0);
		// one period is four quarters of the divide ratio
		count_rises(nr);
		chk(32'(nr), 32'(8 >> dv));
		// clock enable low freezes the pairs wherever they stand
		ce <= 1'b0;
		@(posedge aclk);
		v = {28'h0, ct, cc};
		repeat (5) @(posedge aclk);
		chk({28'h0, ct, cc}, v);
		ce <= 1'b1;
		// hold bit sits in byte lane 0 only
		wstrb <= 4'h0;
		wr(`DCL_OFS_CTRL, 32'h1);
		rd(`DCL_OFS_CTRL);
		chk(v, 32'h0);
		wstrb <= 4'hF;
		// read-only place keeps its value, stray places are refused
		wr(`DCL_OFS_SETTING, 32'hFFFFFFFF);
		chk({30'h0, r}, {30'h0, `DCL_RESP_OKAY});
		rd(`DCL_OFS_SETTING);
		chk(v, exp_set(fr[8:0], dv));
		wr(8'h20, 32'h0);
		chk({30'h0, r}, {30'h0, `DCL_RESP_SLVERR});
		rd(8'h24);
		chk({v[29:0], r}, {30'h0, `DCL_RESP_SLVERR});
		end_of_test();
	end
endmodule
`default_nettype wire
